// [rtl/dmshp_port.sv]
// Dual-mode I2C / SPI configuration port front end with status interrupt
// Function
// R1: The select pin high runs the port as an I2C target and low runs it as an SPI target.
// R2: The data pin is the two-way data line in I2C and 3-wire SPI, and input only in 4-wire SPI.
// R3: In 4-wire SPI the read data is driven out on the address bit one pin.
// R4: In I2C the address bit one pin is sampled as address select bit one.
// R5: The host drives the serial clock and the port uses it in both modes.
// R6: In I2C the chip select pin level is address select bit zero.
// R7: In SPI a transfer is framed by chip select low and the port ignores the clock otherwise.
// R8: The interrupt output goes low when a status change has occurred.
// R9: In I2C the two strap levels form the low two target address bits, the rest fixed.
`timescale 1ns/100ps
`default_nettype none
module dmshp_port #(
  parameter logic [4:0] ADDR_HI = 5'h0A // Fixed upper target address bits
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic i2c_sel_pin, // Mode select pin, high for I2C
  input wire logic sclk_pin, // Serial clock from host
  input wire logic sdio_in, // Data pin level
  output logic sdio_out, // Data pin drive value
  output logic sdio_oe, // Data pin drive enable
  input wire logic addr_bit1_or_read_data_pin_in, // Address bit one / read data pin level
  output logic addr_bit1_or_read_data_pin_out, // Read data pin drive value
  output logic addr_bit1_or_read_data_pin_oe, // Read data pin drive enable
  input wire logic addr_bit0_or_select_n_pin, // Address bit zero / chip select pin
  output logic status_change_irq_n, // Status change interrupt, active low
  input wire logic spi_3wire, // SPI uses the shared data pin both ways
  input wire logic spi_read_dir, // 3-wire SPI: port drives the data pin
  input wire logic status_event, // Status change pulse from the device
  input wire logic irq_clear, // Clear pulse for the interrupt
  input wire logic [7:0] tx_data, // Next read byte for the host
  output logic tx_req, // Pulse: tx_data was taken
  output logic [7:0] rx_data, // Last byte written by the host
  output logic rx_valid, // Pulse: rx_data is new
  output logic addr_match, // Pulse: I2C address matched
  output logic i2c_mode // Port is in I2C mode
);

  // ==========================================================================
  // Pin synchronisation and edge detection
  logic [dmshp_pkg::SYNC_W-1:0] pins_s;
  logic sclk_s;
  logic sda_s;
  logic a1_s;
  logic a0_s;
  logic sclk_d;
  logic sda_d;
  logic spi_act_d;
  logic sclk_rise;
  logic sclk_fall;
  logic i2c_start;
  logic i2c_stop;
  logic spi_active;
  logic [dmshp_pkg::I2C_ADDR_W-1:0] own_addr;

  dmshp_sync #(
    .WIDTH(dmshp_pkg::SYNC_W),
    .RST_VAL(dmshp_pkg::SYNC_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({i2c_sel_pin, sclk_pin, sdio_in, addr_bit1_or_read_data_pin_in, addr_bit0_or_select_n_pin}),
    .q(pins_s)
  );

  assign i2c_mode = pins_s[dmshp_pkg::SYNC_SEL]; // R1
  assign sclk_s = pins_s[dmshp_pkg::SYNC_SCLK];
  assign sda_s = pins_s[dmshp_pkg::SYNC_SDA];
  assign a1_s = pins_s[dmshp_pkg::SYNC_A1];
  assign a0_s = pins_s[dmshp_pkg::SYNC_A0];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_d <= 1'b1;
      sda_d <= 1'b1;
      spi_act_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      sda_d <= sda_s;
      spi_act_d <= spi_active;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d; // R5
  assign sclk_fall = ~sclk_s & sclk_d; // R5
  assign i2c_start = i2c_mode & sclk_s & sclk_d & sda_d & ~sda_s;
  assign i2c_stop = i2c_mode & sclk_s & sclk_d & ~sda_d & sda_s;
  assign spi_active = ~i2c_mode & ~a0_s; // R7
  // Straps are read live so a board change is seen at the next address phase
  assign own_addr = {ADDR_HI, a1_s, a0_s}; // R4 R6 R9

  // ==========================================================================
  // Transfer engine
  dmshp_pkg::dmshp_state_t state;
  // Local copies of the state names, since the package is never imported
  localparam dmshp_pkg::dmshp_state_t DMSHP_IDLE = dmshp_pkg::DMSHP_IDLE;
  localparam dmshp_pkg::dmshp_state_t DMSHP_ADDR = dmshp_pkg::DMSHP_ADDR;
  localparam dmshp_pkg::dmshp_state_t DMSHP_ADDR_ACK = dmshp_pkg::DMSHP_ADDR_ACK;
  localparam dmshp_pkg::dmshp_state_t DMSHP_WRITE = dmshp_pkg::DMSHP_WRITE;
  localparam dmshp_pkg::dmshp_state_t DMSHP_WR_ACK = dmshp_pkg::DMSHP_WR_ACK;
  localparam dmshp_pkg::dmshp_state_t DMSHP_READ = dmshp_pkg::DMSHP_READ;
  localparam dmshp_pkg::dmshp_state_t DMSHP_RD_ACK = dmshp_pkg::DMSHP_RD_ACK;
  logic [dmshp_pkg::BYTE_BITS-1:0] shift_in;
  logic [dmshp_pkg::BYTE_BITS-1:0] tx_shift;
  logic [dmshp_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic rw;
  logic ack_on;
  logic load_pend;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= DMSHP_IDLE;
      shift_in <= dmshp_pkg::BYTE_RST;
      tx_shift <= dmshp_pkg::BYTE_RST;
      bit_cnt <= dmshp_pkg::CNT_RST;
      rw <= 1'b0;
      ack_on <= 1'b0;
      load_pend <= 1'b0;
      rx_data <= dmshp_pkg::BYTE_RST;
      rx_valid <= 1'b0;
      tx_req <= 1'b0;
      addr_match <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      tx_req <= 1'b0;
      addr_match <= 1'b0;
      if (i2c_mode) // R1
      begin
        if (i2c_start)
        begin
          state <= DMSHP_ADDR;
          bit_cnt <= dmshp_pkg::CNT_RST;
          ack_on <= 1'b0;
          load_pend <= 1'b0;
        end
        else if (i2c_stop)
        begin
          state <= DMSHP_IDLE;
          ack_on <= 1'b0;
        end
        else if (sclk_rise)
        begin
          case (state)
            DMSHP_ADDR:
            begin
              shift_in <= {shift_in[6:0], sda_s};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == dmshp_pkg::LAST_BIT)
              begin
                if (shift_in[6:0] == own_addr) // R9
                begin
                  state <= DMSHP_ADDR_ACK;
                  rw <= sda_s;
                  addr_match <= 1'b1;
                end
                else
                begin
                  state <= DMSHP_IDLE;
                end
              end
            end
            DMSHP_WRITE:
            begin
              shift_in <= {shift_in[6:0], sda_s};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == dmshp_pkg::LAST_BIT)
              begin
                rx_data <= {shift_in[6:0], sda_s};
                rx_valid <= 1'b1;
                state <= DMSHP_WR_ACK;
              end
            end
            DMSHP_READ:
            begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == dmshp_pkg::LAST_BIT)
              begin
                state <= DMSHP_RD_ACK;
              end
            end
            DMSHP_RD_ACK:
            begin
              // A host NACK ends the read; wait for stop or restart
              if (sda_s)
              begin
                state <= DMSHP_IDLE;
              end
              else
              begin
                state <= DMSHP_READ;
                load_pend <= 1'b1;
              end
            end
            default:
            begin
              state <= state;
            end
          endcase
        end
        else if (sclk_fall)
        begin
          case (state)
            DMSHP_ADDR_ACK, DMSHP_WR_ACK:
            begin
              if (!ack_on)
              begin
                ack_on <= 1'b1;
              end
              else
              begin
                ack_on <= 1'b0;
                if (state == DMSHP_ADDR_ACK && rw)
                begin
                  state <= DMSHP_READ;
                  tx_shift <= tx_data;
                  tx_req <= 1'b1;
                end
                else
                begin
                  state <= DMSHP_WRITE;
                end
              end
            end
            DMSHP_READ:
            begin
              if (load_pend)
              begin
                tx_shift <= tx_data;
                tx_req <= 1'b1;
                load_pend <= 1'b0;
              end
              else
              begin
                tx_shift <= {tx_shift[6:0], 1'b0};
              end
            end
            default:
            begin
              state <= state;
            end
          endcase
        end
      end
      else
      begin
        state <= DMSHP_IDLE;
        ack_on <= 1'b0;
        if (!spi_active) // R7
        begin
          bit_cnt <= dmshp_pkg::CNT_RST;
          load_pend <= 1'b0;
        end
        else if (!spi_act_d)
        begin
          // First bit must be on the pin before the first rising clock
          tx_shift <= tx_data;
          tx_req <= 1'b1;
        end
        else if (sclk_rise)
        begin
          shift_in <= {shift_in[6:0], sda_s}; // R2
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == dmshp_pkg::LAST_BIT)
          begin
            rx_data <= {shift_in[6:0], sda_s};
            rx_valid <= 1'b1;
            load_pend <= 1'b1;
          end
        end
        else if (sclk_fall)
        begin
          if (load_pend)
          begin
            tx_shift <= tx_data;
            tx_req <= 1'b1;
            load_pend <= 1'b0;
          end
          else
          begin
            tx_shift <= {tx_shift[6:0], 1'b0};
          end
        end
      end
    end
  end

  // ==========================================================================
  // Pin drivers
  // I2C data is open drain: only ever pulled low
  assign sdio_out = i2c_mode ? 1'b0 : tx_shift[7]; // R2
  assign sdio_oe = i2c_mode ?
    (ack_on | (state == DMSHP_READ && !load_pend && !tx_shift[7])) :
    (spi_active & spi_3wire & spi_read_dir); // R2
  assign addr_bit1_or_read_data_pin_out = tx_shift[7]; // R3
  assign addr_bit1_or_read_data_pin_oe = spi_active & ~spi_3wire; // R3 R4

  // ==========================================================================
  // Status interrupt; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      status_change_irq_n <= 1'b1;
    end
    else
    begin
      status_change_irq_n <= ~(status_event | (~status_change_irq_n & ~irq_clear)); // R8
    end
  end

  // ==========================================================================
  // Checks
  sequence seq_event;
    status_event;
  endsequence

  sequence seq_irq_low;
    !status_change_irq_n;
  endsequence

  chk_irq_on_event: assert property (@(posedge clk_sys) disable iff (!nrst) seq_event |=> seq_irq_low) // R8
    else $error("interrupt not asserted after status event");
  chk_irq_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!status_change_irq_n && !irq_clear) |=> !status_change_irq_n) // R8
    else $error("interrupt dropped without clear");
  chk_sdo_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    (i2c_mode || a0_s) |-> !addr_bit1_or_read_data_pin_oe) // R3
    else $error("read data pin driven outside an SPI frame");
  chk_a1_input_i2c: assert property (@(posedge clk_sys) disable iff (!nrst)
    i2c_mode |-> !addr_bit1_or_read_data_pin_oe) // R4
    else $error("address bit one pin driven in I2C mode");
  chk_sdi_4wire: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!i2c_mode && !spi_3wire) |-> !sdio_oe) // R2
    else $error("data pin driven in 4-wire SPI");
  chk_i2c_open_drain: assert property (@(posedge clk_sys) disable iff (!nrst)
    (i2c_mode && sdio_oe) |-> !sdio_out) // R2
    else $error("I2C data driven high");
  chk_cs_gates_rx: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!i2c_mode && a0_s) |=> !rx_valid) // R7
    else $error("byte received with chip select high");
  chk_rx_from_clock: assert property (@(posedge clk_sys) disable iff (!nrst)
    rx_valid |-> $past(sclk_rise)) // R5
    else $error("byte completed without a serial clock edge");
  chk_addr_straps: assert property (@(posedge clk_sys) disable iff (!nrst)
    addr_match |-> ($past(shift_in[1:0]) == $past({a1_s, a0_s}) && $past(i2c_mode))) // R6 R9
    else $error("address matched against wrong strap levels");
  chk_mode_roles: assert property (@(posedge clk_sys) disable iff (!nrst)
    !i2c_mode |=> (!ack_on && state == DMSHP_IDLE)) // R1
    else $error("I2C engine active in SPI mode");

endmodule
`default_nettype wire

// [rtl/dmshp_pkg.sv]
// Shared constants and types for the dual-mode serial host port
package dmshp_pkg;

  // ==========================================================================
  // Serial framing
  localparam int BYTE_BITS = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam int I2C_ADDR_W = 7;
  localparam int I2C_STRAP_W = 2;

  // ==========================================================================
  // Pin synchroniser layout and idle levels
  localparam int SYNC_W = 5;
  localparam int SYNC_SEL = 4;
  localparam int SYNC_SCLK = 3;
  localparam int SYNC_SDA = 2;
  localparam int SYNC_A1 = 1;
  localparam int SYNC_A0 = 0;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h1F;

  // ==========================================================================
  // Reset values
  localparam logic [BYTE_BITS-1:0] BYTE_RST = 8'h00;
  localparam logic [BIT_CNT_W-1:0] CNT_RST = 3'h0;

  // ==========================================================================
  // Transfer engine states, Gray coded along the usual path
  typedef enum logic [2:0] {
    DMSHP_IDLE = 3'h0,
    DMSHP_ADDR = 3'h1,
    DMSHP_ADDR_ACK = 3'h3,
    DMSHP_WRITE = 3'h2,
    DMSHP_WR_ACK = 3'h6,
    DMSHP_READ = 3'h7,
    DMSHP_RD_ACK = 3'h5
  } dmshp_state_t;

endpackage

// [rtl/dmshp_sync.sv]
// Two-stage synchroniser for pin levels entering the system clock domain
`timescale 1ns/100ps
`default_nettype none
module dmshp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous levels
  output logic [WIDTH-1:0] q // Synchronised levels
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// [verification/dmshp_host_model.sv]
// Host-side serial master model: clock, select and data drive
`timescale 1ns/100ps
`default_nettype none
module dmshp_host_model (
  output logic sclk_pin, // Serial clock
  output logic sdio_drv, // Data drive value
  output logic sdio_en, // Data drive enable
  output logic cs_n, // Chip select, active low
  input wire logic sdio_wire, // Data line level
  input wire logic miso_wire // Read data level
);
  initial
  begin
    sclk_pin = 1'b1;
    sdio_drv = 1'b0;
    sdio_en = 1'b0;
    cs_n = 1'b1;
  end
  // ====
  // Bit level, 48 ns period; the clock stands still between frames
  task automatic clk_bit(input logic spi, input logic b, input logic drive, output logic r);
  begin
    #4;
    sdio_en = spi ? drive : ~b;
    sdio_drv = spi & b;
    #20 sclk_pin = 1'b1;
    #12 r = spi ? miso_wire : sdio_wire;
    #12 sclk_pin = 1'b0;
  end
  endtask
  task automatic xfer(input logic spi, input logic drive, input logic [7:0] d, output logic [7:0] q);
    logic r;
  begin
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(spi, d[i], drive, r);
      q[i] = r;
    end
  end
  endtask
  task automatic spi_frame(input logic drive, input logic [7:0] d, output logic [7:0] q);
  begin
    sclk_pin = 1'b0;
    #20 cs_n = 1'b0;
    #60;
    xfer(1'b1, drive, d, q);
    #60 cs_n = 1'b1;
    sdio_en = 1'b0;
  end
  endtask
  // Open drain: enable means pull low
  task automatic i2c_start;
  begin
    sdio_drv = 1'b0;
    sdio_en = 1'b0;
    sclk_pin = 1'b1;
    #48 sdio_en = 1'b1;
    #24 sclk_pin = 1'b0;
  end
  endtask
  task automatic i2c_stop;
  begin
    #4 sdio_en = 1'b1;
    #20 sclk_pin = 1'b1;
    #24 sdio_en = 1'b0;
    #48;
  end
  endtask
endmodule
`default_nettype wire

// [verification/test_dmshp_port.sv]
// Self-checking bench for the dual-mode serial port front end
`timescale 1ns/100ps
`default_nettype none
module test_dmshp_port;
  localparam logic [4:0] HI = 5'h0A;
  logic clk_sys, nrst, sel, a1_strap, a0_strap, spi_3wire, spi_read_dir, status_event, irq_clear;
  logic sdio_out, sdio_oe, a1_out, a1_oe, irq_n, tx_req, rx_valid, addr_match, i2c_mode;
  logic sclk, sdio_drv, sdio_en, cs_n, sdio_keep, sdio_d, sdio_wire, a1_wire;
  logic [7:0] tx_data, rx_data, q, n_rx, n_match, last_rx, n_tx;
  int failures, n_checks;
  // Released SPI line shows the inverse of its last level, I2C line is pulled up
  assign sdio_d = sdio_oe ? sdio_out : sdio_drv;
  assign sdio_wire = (sdio_oe | sdio_en) ? sdio_d : (sel ? 1'b1 : sdio_keep);
  assign a1_wire = a1_oe ? a1_out : a1_strap;
  always @(posedge clk_sys)
  begin
    if (sdio_oe | sdio_en)
      sdio_keep <= ~sdio_d;
    if (rx_valid === 1'b1)
      n_rx <= n_rx + 8'h01;
    if (rx_valid === 1'b1)
      last_rx <= rx_data;
    if (addr_match === 1'b1)
      n_match <= n_match + 8'h01;
    if (tx_req === 1'b1)
      n_tx <= n_tx + 8'h01;
  end
  dmshp_port #(.ADDR_HI(HI)) i_dmshp_port (.clk_sys(clk_sys), .nrst(nrst), .i2c_sel_pin(sel),
    .sclk_pin(sclk), .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .addr_bit1_or_read_data_pin_in(a1_wire), .addr_bit1_or_read_data_pin_out(a1_out),
    .addr_bit1_or_read_data_pin_oe(a1_oe), .addr_bit0_or_select_n_pin(sel ? a0_strap : cs_n),
    .status_change_irq_n(irq_n), .spi_3wire(spi_3wire), .spi_read_dir(spi_read_dir),
    .status_event(status_event), .irq_clear(irq_clear), .tx_data(tx_data), .tx_req(tx_req),
    .rx_data(rx_data), .rx_valid(rx_valid), .addr_match(addr_match), .i2c_mode(i2c_mode));
  dmshp_host_model i_dmshp_host_model (.sclk_pin(sclk), .sdio_drv(sdio_drv), .sdio_en(sdio_en),
    .cs_n(cs_n), .sdio_wire(sdio_wire), .miso_wire(spi_3wire ? sdio_wire : a1_wire));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ====
  // Compare and closing
  task automatic check1(input string name, input logic exp, input logic got);
  begin
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  end
  endtask
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
  begin
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task automatic conclude;
  begin
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // ====
  // Scenarios
  task automatic t_spi4;
    logic [7:0] r0, t0;
  begin
    @(posedge clk_sys);
    sel <= 1'b0;
    tx_data <= 8'hA5;
    repeat (6) @(posedge clk_sys);
    check1("i2c_mode", 1'b0, i2c_mode);
    r0 = n_rx;
    t0 = n_tx;
    i_dmshp_host_model.spi_frame(1'b1, 8'h3C, q);
    repeat (4) @(posedge clk_sys);
    check8("tx request count", t0 + 8'h02, n_tx);
    check8("spi read byte", 8'hA5, q);
    check8("spi write byte", 8'h3C, last_rx);
    // Clock with select high must be ignored
    i_dmshp_host_model.xfer(1'b1, 1'b1, 8'hFF, q);
    repeat (6) @(posedge clk_sys);
    check8("rx count", r0 + 8'h01, n_rx);
    check8("tx count idle", t0 + 8'h02, n_tx);
    check1("read pin enable", 1'b0, a1_oe);
    $display("test spi4 done");
  end
  endtask
  task automatic t_spi3;
  begin
    @(posedge clk_sys);
    spi_3wire <= 1'b1;
    i_dmshp_host_model.spi_frame(1'b1, 8'h96, q);
    repeat (4) @(posedge clk_sys);
    check8("3-wire write", 8'h96, last_rx);
    spi_read_dir <= 1'b1;
    tx_data <= 8'h5C;
    i_dmshp_host_model.spi_frame(1'b0, 8'h00, q);
    check8("3-wire read", 8'h5C, q);
    @(posedge clk_sys);
    spi_read_dir <= 1'b0;
    spi_3wire <= 1'b0;
    $display("test spi3 done");
  end
  endtask
  task automatic t_i2c(input logic s1, input logic s0, input logic [1:0] lo, input logic [7:0] d);
    logic ack, dack, hit;
    logic [7:0] m0, r0;
  begin
    @(posedge clk_sys);
    sel <= 1'b1;
    a1_strap <= s1;
    a0_strap <= s0;
    repeat (6) @(posedge clk_sys);
    hit = ({s1, s0} == lo);
    m0 = n_match;
    r0 = n_rx;
    i_dmshp_host_model.i2c_start();
    i_dmshp_host_model.xfer(1'b0, 1'b1, {HI, lo, 1'b0}, q);
    i_dmshp_host_model.clk_bit(1'b0, 1'b1, 1'b1, ack);
    i_dmshp_host_model.xfer(1'b0, 1'b1, d, q);
    i_dmshp_host_model.clk_bit(1'b0, 1'b1, 1'b1, dack);
    i_dmshp_host_model.i2c_stop();
    check1("i2c_mode", 1'b1, i2c_mode);
    check1("address ack", ~hit, ack);
    check1("data ack", ~hit, dack);
    check8("match count", m0 + {7'h00, hit}, n_match);
    check8("rx count", r0 + {7'h00, hit}, n_rx);
    if (hit)
      check8("i2c write byte", d, last_rx);
    $display("test i2c done");
  end
  endtask
  task automatic t_irq;
  begin
    check1("irq idle", 1'b1, irq_n);
    @(posedge clk_sys);
    status_event <= 1'b1;
    @(posedge clk_sys);
    status_event <= 1'b0;
    #1 check1("irq set", 1'b0, irq_n);
    @(posedge clk_sys);
    irq_clear <= 1'b1;
    status_event <= 1'b1;
    @(posedge clk_sys);
    status_event <= 1'b0;
    #1 check1("irq set wins", 1'b0, irq_n);
    @(posedge clk_sys);
    irq_clear <= 1'b0;
    #1 check1("irq cleared", 1'b1, irq_n);
    $display("test irq done");
  end
  endtask
  initial
  begin
    nrst = 1'b0;
    sel = 1'b1;
    a1_strap = 1'b1;
    a0_strap = 1'b1;
    spi_3wire = 1'b0;
    spi_read_dir = 1'b0;
    status_event = 1'b0;
    irq_clear = 1'b0;
    tx_data = 8'h00;
    n_rx = 8'h00;
    n_match = 8'h00;
    n_tx = 8'h00;
    last_rx = 8'h00;
    sdio_keep = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_irq;
    t_spi4;
    t_spi3;
    t_i2c(1'b1, 1'b0, 2'b10, 8'hC3);
    t_i2c(1'b0, 1'b1, 2'b01, 8'h3E);
    t_i2c(1'b0, 1'b1, 2'b10, 8'h11);
    t_i2c(1'b1, 1'b1, 2'b10, 8'h22);
    conclude;
  end
  initial
  begin
    #60000;
    failures++;
    $display("ERROR watchdog expected done seen timeout");
    conclude;
  end
endmodule
`default_nettype wire
